// ===== core/adc_config_register_bank.sv
// Configuration register bank with serial write/readback and output test_source_select.
// Assumes sample and overrange inputs arrive on CLK; the format pin is asynchronous.
`timescale 1ns/1ns
// What this block does
// - Capture a bit per falling serial edge; 16 bits give address then data
// - A write updates all fields of a register from one data byte
// - Soft-reset bit restores defaults and then clears itself
// - Readback bit selects overrange flag or serial readback on the shared pin
// - In readback mode only address zero is writable; address zero reads zero
// - Six-bit swing code selects the output swing
// - Swing code acts only while swing enable is set, else default swing
// - Gain field selects gain in half-decibel steps
// - Test source 000 passes samples, 001 all low, 010 all high
// - Test source 011 alternates the toggle word and its complement
// - Test source 100 ramps one code every eighth sample clock, 0 to 2047
// - Test source 101 outputs the user word; 110 and 111 unused
// - User word is high register then three top bits of low register
// - Format field: pin decides, forced twos complement or offset binary
// - Format register bit 5 enables the DC offset loop
// - Format register bit 4 enables noise shaping
// - Two four-bit noise shaping coefficients held in two registers
module adc_config_register_bank #(
  parameter bit NINE_BIT_VARIANT = 1'b0
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Serial configuration port
  input wire logic SERIAL_CLK,
  input wire logic SERIAL_SELECT_N,
  input wire logic SERIAL_DATA_IN,
  // Converter side
  input wire logic [10:0] ADC_SAMPLE,
  input wire logic OVERRANGE_IN,
  input wire logic FORMAT_INTERFACE_PIN,
  // Shared pin and data output
  output logic OVERRANGE_READBACK_PIN,
  output logic [10:0] DATA_OUT,
  output logic TWOS_COMPLEMENT,
  // Analog and driver controls
  output logic [5:0] SWING_CODE,
  output logic [2:0] GAIN_HALF_DB,
  output logic CLOCK_DRIVER_DOUBLE,
  output logic DATA_DRIVER_DOUBLE,
  output logic DC_OFFSET_LOOP_ENABLE,
  output logic NOISE_SHAPING_ENABLE,
  output logic [3:0] NOISE_SHAPING_COEF_A,
  output logic [3:0] NOISE_SHAPING_COEF_B,
  // Raw contents of the remaining registers
  output logic [7:0] INTERFACE_CLOCK_EDGE,
  output logic [7:0] FALL_EDGE_LATENCY_STANDBY,
  output logic [7:0] POWER_DOWN_SWING,
  output logic [7:0] OFFSET_PEDESTAL,
  output logic [7:0] OFFSET_LOOP_TIMING,
  output logic [7:0] LOW_RATE_MODE,
  output logic [7:0] SHAPING_PIN_OVERRIDE
);
  cfg_serial_if bus ();

  adc_cfg_pkg::byte_t regs [adc_cfg_pkg::NUM_REGS];
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic wr_allowed;
  logic readback;
  logic soft_reset;
  logic fmt_s1, fmt_s2;
  logic [2:0] test_source;
  logic [1:0] format_sel;
  logic twos_sel;
  logic toggle_phase;
  logic [2:0] ramp_div;
  logic [10:0] ramp_code;
  logic [10:0] toggle_word;
  logic [10:0] custom_word;
  logic [10:0] next_data;
  logic [8*adc_cfg_pkg::NUM_REGS-1:0] regs_flat;

  cfg_serial_shifter u_shifter (
    .clk(CLK),
    .rst_n(RST_N),
    .sclk_pin(SERIAL_CLK),
    .select_n_pin(SERIAL_SELECT_N),
    .sdi_pin(SERIAL_DATA_IN),
    .bus(bus.shifter)
  );

  assign readback = regs[adc_cfg_pkg::IDX_SOFT_RESET_READBACK_CTRL][adc_cfg_pkg::BIT_READBACK];
  assign soft_reset =
    regs[adc_cfg_pkg::IDX_SOFT_RESET_READBACK_CTRL][adc_cfg_pkg::BIT_SOFT_RESET];
  assign wr_idx = adc_cfg_pkg::reg_index(bus.wr_addr);
  assign rd_idx = adc_cfg_pkg::reg_index(bus.rd_addr);
  assign wr_allowed = (wr_idx != adc_cfg_pkg::IDX_NONE) &&
    (!readback || wr_idx == adc_cfg_pkg::IDX_SOFT_RESET_READBACK_CTRL);

  // Register storage; the soft-reset bit lives one cycle, then clears everything
  always_ff @(posedge CLK) begin
    if (!RST_N || soft_reset) begin
      for (int i = 0; i < adc_cfg_pkg::NUM_REGS; i++) begin
        regs[i] <= adc_cfg_pkg::REG_DEFAULT;
      end
    end else if (bus.wr_strobe && wr_allowed) begin
      regs[wr_idx] <= bus.wr_data & adc_cfg_pkg::REG_MASK[wr_idx];
    end
  end

  // Readback source; address zero and unmapped addresses read zero
  always_comb begin
    bus.rd_data = 8'h00;
    if (rd_idx != adc_cfg_pkg::IDX_NONE &&
        rd_idx != adc_cfg_pkg::IDX_SOFT_RESET_READBACK_CTRL) begin
      bus.rd_data = regs[rd_idx];
    end
  end

  // Shared pin role
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      OVERRANGE_READBACK_PIN <= 1'b0;
    end else begin
      OVERRANGE_READBACK_PIN <= readback ? bus.sdo : OVERRANGE_IN;
    end
  end

  // Format pin synchroniser
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fmt_s1 <= 1'b0;
      fmt_s2 <= 1'b0;
    end else begin
      fmt_s1 <= FORMAT_INTERFACE_PIN;
      fmt_s2 <= fmt_s1;
    end
  end

  assign test_source = regs[adc_cfg_pkg::IDX_GAIN_AND_TEST_PATTERN][
    adc_cfg_pkg::TEST_MSB:adc_cfg_pkg::TEST_LSB];
  assign format_sel = regs[adc_cfg_pkg::IDX_FORMAT_OFFSET_SHAPING_CTRL][
    adc_cfg_pkg::FORMAT_MSB:adc_cfg_pkg::FORMAT_LSB];
  // Pin high means straight binary; undefined code 01 also defers to the pin
  assign twos_sel = (format_sel == adc_cfg_pkg::FMT_TWOS) ||
    (format_sel != adc_cfg_pkg::FMT_OFFSET && !fmt_s2);
  assign custom_word = {regs[adc_cfg_pkg::IDX_USER_PATTERN_HIGH],
    regs[adc_cfg_pkg::IDX_USER_PATTERN_LOW][
    adc_cfg_pkg::USER_LOW_MSB:adc_cfg_pkg::USER_LOW_LSB]};
  assign toggle_word = NINE_BIT_VARIANT ?
    {2'b00, (toggle_phase ? ~adc_cfg_pkg::TOGGLE_NARROW : adc_cfg_pkg::TOGGLE_NARROW)} :
    (toggle_phase ? ~adc_cfg_pkg::TOGGLE_WIDE : adc_cfg_pkg::TOGGLE_WIDE);

  // Pattern generators restart whenever their source is deselected
  always_ff @(posedge CLK) begin
    if (!RST_N || test_source != adc_cfg_pkg::SRC_TOGGLE) begin
      toggle_phase <= 1'b0;
    end else begin
      toggle_phase <= ~toggle_phase;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N || test_source != adc_cfg_pkg::SRC_RAMP) begin
      ramp_div <= 3'h0;
      ramp_code <= adc_cfg_pkg::RAMP_START;
    end else begin
      ramp_div <= 3'(ramp_div + 3'h1);
      if (ramp_div == adc_cfg_pkg::RAMP_STEP_LAST) begin
        ramp_code <= 11'(ramp_code + 11'h001);
      end
    end
  end

  always_comb begin
    next_data = adc_cfg_pkg::DATA_ZERO;
    case (test_source)
      adc_cfg_pkg::SRC_NORMAL: begin
        next_data = twos_sel ? {~ADC_SAMPLE[10], ADC_SAMPLE[9:0]} : ADC_SAMPLE;
      end
      adc_cfg_pkg::SRC_ZEROS: begin
        next_data = adc_cfg_pkg::DATA_ZERO;
      end
      adc_cfg_pkg::SRC_ONES: begin
        next_data = adc_cfg_pkg::DATA_ONES;
      end
      adc_cfg_pkg::SRC_TOGGLE: begin
        next_data = toggle_word;
      end
      adc_cfg_pkg::SRC_RAMP: begin
        next_data = ramp_code;
      end
      adc_cfg_pkg::SRC_CUSTOM: begin
        next_data = custom_word;
      end
      default: begin
        next_data = adc_cfg_pkg::DATA_ZERO;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      DATA_OUT <= adc_cfg_pkg::DATA_ZERO;
      TWOS_COMPLEMENT <= 1'b0;
    end else begin
      DATA_OUT <= next_data;
      TWOS_COMPLEMENT <= twos_sel;
    end
  end

  // Swing and gain controls
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      SWING_CODE <= adc_cfg_pkg::SWING_DEFAULT;
      GAIN_HALF_DB <= 3'h0;
    end else begin
      if (regs[adc_cfg_pkg::IDX_POWER_DOWN_SWING_ENABLE][
          adc_cfg_pkg::SWING_EN_MSB:adc_cfg_pkg::SWING_EN_LSB] == adc_cfg_pkg::SWING_EN_ON) begin
        SWING_CODE <= regs[adc_cfg_pkg::IDX_OUTPUT_SWING_CODE][
          adc_cfg_pkg::SWING_MSB:adc_cfg_pkg::SWING_LSB];
      end else begin
        SWING_CODE <= adc_cfg_pkg::SWING_DEFAULT;
      end
      GAIN_HALF_DB <= adc_cfg_pkg::gain_half_db(regs[adc_cfg_pkg::IDX_GAIN_AND_TEST_PATTERN][
        adc_cfg_pkg::GAIN_MSB:adc_cfg_pkg::GAIN_LSB]);
    end
  end

  // Direct register fields
  assign CLOCK_DRIVER_DOUBLE =
    regs[adc_cfg_pkg::IDX_OUTPUT_DRIVE_STRENGTH][adc_cfg_pkg::BIT_CLOCK_DRIVER];
  assign DATA_DRIVER_DOUBLE =
    regs[adc_cfg_pkg::IDX_OUTPUT_DRIVE_STRENGTH][adc_cfg_pkg::BIT_DATA_DRIVER];
  assign DC_OFFSET_LOOP_ENABLE =
    regs[adc_cfg_pkg::IDX_FORMAT_OFFSET_SHAPING_CTRL][adc_cfg_pkg::BIT_DC_OFFSET_LOOP];
  assign NOISE_SHAPING_ENABLE =
    regs[adc_cfg_pkg::IDX_FORMAT_OFFSET_SHAPING_CTRL][adc_cfg_pkg::BIT_NOISE_SHAPING];
  assign NOISE_SHAPING_COEF_A = regs[adc_cfg_pkg::IDX_FORMAT_OFFSET_SHAPING_CTRL][
    adc_cfg_pkg::COEF_A_MSB:adc_cfg_pkg::COEF_A_LSB];
  assign NOISE_SHAPING_COEF_B = regs[adc_cfg_pkg::IDX_SHAPING_COEFFICIENT_TWO][
    adc_cfg_pkg::COEF_B_MSB:adc_cfg_pkg::COEF_B_LSB];
  assign INTERFACE_CLOCK_EDGE = regs[adc_cfg_pkg::IDX_INTERFACE_CLOCK_EDGE_CTRL];
  assign FALL_EDGE_LATENCY_STANDBY = regs[adc_cfg_pkg::IDX_FALL_EDGE_LATENCY_STANDBY];
  assign POWER_DOWN_SWING = regs[adc_cfg_pkg::IDX_POWER_DOWN_SWING_ENABLE];
  assign OFFSET_PEDESTAL = regs[adc_cfg_pkg::IDX_OFFSET_PEDESTAL_CTRL];
  assign OFFSET_LOOP_TIMING = regs[adc_cfg_pkg::IDX_OFFSET_LOOP_TIMING];
  assign LOW_RATE_MODE = regs[adc_cfg_pkg::IDX_LOW_RATE_MODE_CTRL];
  assign SHAPING_PIN_OVERRIDE = regs[adc_cfg_pkg::IDX_SHAPING_PIN_OVERRIDE];

  // Flattened view for stability checks
  always_comb begin
    regs_flat = '0;
    for (int i = 0; i < adc_cfg_pkg::NUM_REGS; i++) begin
      regs_flat[8*i +: 8] = regs[i];
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  sequence soft_reset_write;
    bus.wr_strobe && wr_idx == adc_cfg_pkg::IDX_SOFT_RESET_READBACK_CTRL &&
      bus.wr_data[adc_cfg_pkg::BIT_SOFT_RESET];
  endsequence
  sequence defaults_after_pulse;
    soft_reset ##1 (!soft_reset && regs_flat == '0);
  endsequence
  sequence ramp_held;
    (test_source == adc_cfg_pkg::SRC_RAMP) [*2];
  endsequence

  write_applies_a: assert property (
    bus.wr_strobe && wr_allowed && wr_idx != adc_cfg_pkg::IDX_SOFT_RESET_READBACK_CTRL
      && !soft_reset |=> regs[$past(wr_idx)] == ($past(bus.wr_data) &
      adc_cfg_pkg::REG_MASK[$past(wr_idx)]))
    else $error("register not updated by write");
  soft_reset_a: assert property (
    soft_reset_write |=> defaults_after_pulse)
    else $error("soft reset did not restore defaults");
  readback_cleared_a: assert property (
    soft_reset |=> !readback ##1 OVERRANGE_READBACK_PIN == $past(OVERRANGE_IN))
    else $error("soft reset left readback mode on");
  write_ignored_a: assert property (
    readback && !soft_reset && bus.wr_strobe &&
      wr_idx != adc_cfg_pkg::IDX_SOFT_RESET_READBACK_CTRL |=> $stable(regs_flat))
    else $error("write accepted in readback mode");
  hidden_zero_a: assert property (
    bus.rd_addr == adc_cfg_pkg::REG_ADDR[0] |-> bus.rd_data == 8'h00)
    else $error("address zero contents exposed");
  pin_role_a: assert property (
    $past(readback) |-> OVERRANGE_READBACK_PIN == $past(bus.sdo))
    else $error("shared pin not in readback role");
  swing_default_a: assert property (
    $past(POWER_DOWN_SWING[1:0]) != adc_cfg_pkg::SWING_EN_ON |-> SWING_CODE == 6'h00)
    else $error("swing code active without enable");
  swing_code_a: assert property (
    $past(POWER_DOWN_SWING[1:0]) == adc_cfg_pkg::SWING_EN_ON |->
      SWING_CODE == $past(regs[adc_cfg_pkg::IDX_OUTPUT_SWING_CODE][7:2]))
    else $error("swing code not forwarded");
  gain_step_a: assert property (
    regs[adc_cfg_pkg::IDX_GAIN_AND_TEST_PATTERN][7:4] == 4'hC [*2] |-> GAIN_HALF_DB == 3'h7)
    else $error("top gain step wrong");
  force_level_a: assert property (
    $past(test_source) == adc_cfg_pkg::SRC_ONES |-> DATA_OUT == 11'h7FF)
    else $error("all-ones pattern wrong");
  toggle_pattern_a: assert property (
    (test_source == adc_cfg_pkg::SRC_TOGGLE) [*2] |=> (DATA_OUT ^ $past(DATA_OUT)) ==
      (NINE_BIT_VARIANT ? adc_cfg_pkg::NARROW_ONES : adc_cfg_pkg::DATA_ONES))
    else $error("toggle pattern did not alternate");
  ramp_step_a: assert property (
    ramp_held ##0 ramp_div == adc_cfg_pkg::RAMP_STEP_LAST |=>
      ramp_code == 11'($past(ramp_code) + 11'h001) && DATA_OUT == $past(ramp_code))
    else $error("ramp did not advance on eighth clock");
  ramp_hold_a: assert property (
    ramp_held ##0 ramp_div != adc_cfg_pkg::RAMP_STEP_LAST |=> $stable(ramp_code))
    else $error("ramp advanced early");
  custom_word_a: assert property (
    $past(test_source) == adc_cfg_pkg::SRC_CUSTOM |->
      DATA_OUT == {$past(regs[6]), $past(regs[7][7:5])})
    else $error("custom word mismatch");

endmodule // adc_config_register_bank

// ===== core/adc_cfg_pkg.sv
// Constants, register map and decode helpers for the converter configuration bank.
// Assumes one system clock; every serial-port pin is treated as asynchronous to it.
package adc_cfg_pkg;

  typedef logic [7:0] byte_t;

  localparam int NUM_REGS = 15;
  localparam logic [3:0] IDX_NONE = 4'hF;
  localparam byte_t REG_DEFAULT = 8'h00;

  // Register offsets, in index order
  localparam byte_t REG_ADDR [NUM_REGS] = '{
    8'h00, 8'h01, 8'h25, 8'h26, 8'h3D, 8'h3E, 8'h3F, 8'h40,
    8'h41, 8'h42, 8'h43, 8'hBF, 8'hCF, 8'hDF, 8'hEA
  };

  // Writable bits of each register; reserved bits are stored and read as zero
  localparam byte_t REG_MASK [NUM_REGS] = '{
    8'h03, 8'hFC, 8'hF7, 8'h03, 8'hFF, 8'hF0, 8'hFF, 8'hE0,
    8'hFF, 8'hCD, 8'h53, 8'hE0, 8'hBC, 8'h30, 8'h80
  };

  // Register indices
  localparam logic [3:0] IDX_SOFT_RESET_READBACK_CTRL = 4'h0;
  localparam logic [3:0] IDX_OUTPUT_SWING_CODE = 4'h1;
  localparam logic [3:0] IDX_GAIN_AND_TEST_PATTERN = 4'h2;
  localparam logic [3:0] IDX_OUTPUT_DRIVE_STRENGTH = 4'h3;
  localparam logic [3:0] IDX_FORMAT_OFFSET_SHAPING_CTRL = 4'h4;
  localparam logic [3:0] IDX_SHAPING_COEFFICIENT_TWO = 4'h5;
  localparam logic [3:0] IDX_USER_PATTERN_HIGH = 4'h6;
  localparam logic [3:0] IDX_USER_PATTERN_LOW = 4'h7;
  localparam logic [3:0] IDX_INTERFACE_CLOCK_EDGE_CTRL = 4'h8;
  localparam logic [3:0] IDX_FALL_EDGE_LATENCY_STANDBY = 4'h9;
  localparam logic [3:0] IDX_POWER_DOWN_SWING_ENABLE = 4'hA;
  localparam logic [3:0] IDX_OFFSET_PEDESTAL_CTRL = 4'hB;
  localparam logic [3:0] IDX_OFFSET_LOOP_TIMING = 4'hC;
  localparam logic [3:0] IDX_LOW_RATE_MODE_CTRL = 4'hD;
  localparam logic [3:0] IDX_SHAPING_PIN_OVERRIDE = 4'hE;

  // Field positions
  localparam int BIT_READBACK = 0;
  localparam int BIT_SOFT_RESET = 1;
  localparam int SWING_MSB = 7;
  localparam int SWING_LSB = 2;
  localparam int GAIN_MSB = 7;
  localparam int GAIN_LSB = 4;
  localparam int TEST_MSB = 2;
  localparam int TEST_LSB = 0;
  localparam int BIT_CLOCK_DRIVER = 1;
  localparam int BIT_DATA_DRIVER = 0;
  localparam int FORMAT_MSB = 7;
  localparam int FORMAT_LSB = 6;
  localparam int BIT_DC_OFFSET_LOOP = 5;
  localparam int BIT_NOISE_SHAPING = 4;
  localparam int COEF_A_MSB = 3;
  localparam int COEF_A_LSB = 0;
  localparam int COEF_B_MSB = 7;
  localparam int COEF_B_LSB = 4;
  localparam int USER_LOW_MSB = 7;
  localparam int USER_LOW_LSB = 5;
  localparam int SWING_EN_MSB = 1;
  localparam int SWING_EN_LSB = 0;

  // Field encodings
  localparam logic [1:0] SWING_EN_ON = 2'h3;
  localparam logic [5:0] SWING_DEFAULT = 6'h00;
  localparam logic [1:0] FMT_TWOS = 2'h2;
  localparam logic [1:0] FMT_OFFSET = 2'h3;
  localparam logic [3:0] GAIN_FIRST_STEP = 4'h6;
  localparam logic [3:0] GAIN_LAST_STEP = 4'hC;
  localparam logic [3:0] GAIN_STEP_BASE = 4'h5;

  typedef enum logic [2:0] {
    SRC_NORMAL = 3'h0,
    SRC_ZEROS = 3'h1,
    SRC_ONES = 3'h2,
    SRC_TOGGLE = 3'h3,
    SRC_RAMP = 3'h4,
    SRC_CUSTOM = 3'h5
  } test_source_e;

  // Output word patterns
  localparam logic [10:0] DATA_ZERO = 11'h000;
  localparam logic [10:0] DATA_ONES = 11'h7FF;
  localparam logic [10:0] NARROW_ONES = 11'h1FF;
  localparam logic [10:0] TOGGLE_WIDE = 11'h2AA;
  localparam logic [8:0] TOGGLE_NARROW = 9'h0AA;
  localparam logic [2:0] RAMP_STEP_LAST = 3'h7;
  localparam logic [10:0] RAMP_START = 11'h000;

  // Serial word framing
  localparam logic [3:0] ADDR_LAST_BIT = 4'h7;
  localparam logic [3:0] WORD_LAST_BIT = 4'hF;

  function automatic logic [3:0] reg_index(input byte_t a);
    logic [3:0] idx;
    idx = IDX_NONE;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (REG_ADDR[i] == a) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // Gain code to half-decibel steps; undefined codes read as 0 dB
  function automatic logic [2:0] gain_half_db(input logic [3:0] code);
    logic [2:0] steps;
    steps = 3'h0;
    if (code >= GAIN_FIRST_STEP && code <= GAIN_LAST_STEP) begin
      steps = 3'(code - GAIN_STEP_BASE);
    end
    return steps;
  endfunction

endpackage

// ===== core/cfg_serial_if.sv
// Link between the serial shifter and the register bank.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface cfg_serial_if;
  logic wr_strobe;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic rd_load;
  logic [7:0] rd_data;
  logic sdo;

  modport shifter (
    output wr_strobe, wr_addr, wr_data, rd_addr, rd_load, sdo,
    input rd_data
  );
  modport bank (
    input wr_strobe, wr_addr, wr_data, rd_addr, rd_load, sdo,
    output rd_data
  );
endinterface

// ===== core/cfg_serial_shifter.sv
// Three-wire serial shifter: synchronises the pins, frames 16-bit words, shifts readback.
// Assumes the serial clock is much slower than the system clock (at least 4x).
`timescale 1ns/1ns
module cfg_serial_shifter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic sclk_pin,
  input wire logic select_n_pin,
  input wire logic sdi_pin,
  // Bank side
  cfg_serial_if.shifter bus
);
  logic sclk_s1, sclk_s2, sclk_s3;
  logic sel_s1, sel_s2;
  logic sdi_s1, sdi_s2;
  logic [14:0] shift;
  logic [3:0] bit_cnt;
  logic [7:0] rd_shift;
  logic sclk_fall;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_s1 <= 1'b1;
      sclk_s2 <= 1'b1;
      sclk_s3 <= 1'b1;
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end else begin
      sclk_s1 <= sclk_pin;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      sel_s1 <= select_n_pin;
      sel_s2 <= sel_s1;
      sdi_s1 <= sdi_pin;
      sdi_s2 <= sdi_s1;
    end
  end

  assign sclk_fall = sclk_s3 & ~sclk_s2 & ~sel_s2;

  // Word framing; a partial word is dropped when select rises
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift <= '0;
      bit_cnt <= 4'h0;
      bus.wr_strobe <= 1'b0;
      bus.wr_addr <= 8'h00;
      bus.wr_data <= 8'h00;
      bus.rd_addr <= 8'h00;
      bus.rd_load <= 1'b0;
    end else begin
      bus.wr_strobe <= 1'b0;
      bus.rd_load <= 1'b0;
      if (sel_s2) begin
        bit_cnt <= 4'h0;
      end else if (sclk_fall) begin
        shift <= {shift[13:0], sdi_s2};
        bit_cnt <= 4'(bit_cnt + 4'h1);
        if (bit_cnt == adc_cfg_pkg::ADDR_LAST_BIT) begin
          bus.rd_addr <= {shift[6:0], sdi_s2};
          bus.rd_load <= 1'b1;
        end
        if (bit_cnt == adc_cfg_pkg::WORD_LAST_BIT) begin
          bus.wr_addr <= shift[14:7];
          bus.wr_data <= {shift[6:0], sdi_s2};
          bus.wr_strobe <= 1'b1;
        end
      end
    end
  end

  // Readback shifter: next bit appears after each falling edge of the data phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_shift <= 8'h00;
    end else if (bus.rd_load) begin
      rd_shift <= bus.rd_data;
    end else if (sclk_fall && bit_cnt > adc_cfg_pkg::ADDR_LAST_BIT) begin
      rd_shift <= {rd_shift[6:0], 1'b0};
    end
  end

  assign bus.sdo = rd_shift[7];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  word_strobe_a: assert property (
    sclk_fall && bit_cnt == adc_cfg_pkg::WORD_LAST_BIT |=> bus.wr_strobe ##1 !bus.wr_strobe)
    else $error("word strobe missing after sixteenth edge");
  strobe_framing_a: assert property (
    bus.wr_strobe |-> $past(bit_cnt) == adc_cfg_pkg::WORD_LAST_BIT && bit_cnt == 4'h0)
    else $error("word strobe outside sixteenth edge");
  readback_load_a: assert property (
    bus.rd_load |=> bus.sdo == $past(bus.rd_data[7]))
    else $error("readback first bit wrong");

endmodule // cfg_serial_shifter

// ===== verif/cfg_ctrl_model.sv
// Model of the external controller on the three-wire serial port.
// Assumes the bank samples on falling serial edges, with each half period well above 3 CLK.
`timescale 1ns/1ns
module cfg_ctrl_model (
  // Serial pins
  output logic sclk,
  output logic sel_n,
  output logic sdi,
  // Shared readback pin
  input wire logic sdo
);
  logic [7:0] rd;
  initial begin
    sclk = 1'b1;
    sel_n = 1'b1;
    sdi = 1'b0;
    rd = 8'h00;
  end
  // One 16-bit word, address then data, MSB first
  task automatic xfer(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] w;
    w = {a, d};
    sel_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = w[i];
      #40 sclk = 1'b0;
      if (i < 8) rd = {rd[6:0], sdo};
      #40 sclk = 1'b1;
    end
    #40 sel_n = 1'b1;
    // Released data line does not keep its last level
    sdi = ~sdi;
  endtask
endmodule // cfg_ctrl_model

// ===== verif/adc_config_register_bank_tb_top.sv
// Bench for the configuration bank: table of register writes, then hand tests.
// Assumes the controller model in verif/ and the design under core/.
`timescale 1ns/1ns
module adc_config_register_bank_tb_top;
  logic clk, rst_n, ovr;
  logic [10:0] smp, dout, d0;
  wire sclk, sel_n, sdi, pin;
  logic twos, cdd, ddd, dcl, nse, fmt;
  logic [7:0] ped;
  logic [5:0] swing;
  logic [2:0] gain;
  logic [3:0] ca, cb;
  int miscompares, checked;
  typedef struct {logic [7:0] a; logic [7:0] d; int s; logic [10:0] e;} row_s;
  // Reserved bits always written as zero, codes 110 and 111 never used
  row_s rows [16] = '{
    '{8'h26, 8'h03, 1, 11'h003},
    '{8'h3D, 8'hB5, 2, 11'h035},
    '{8'h3E, 8'hA0, 3, 11'h00A},
    '{8'h55, 8'hFF, 3, 11'h00A},
    '{8'h01, 8'hC8, 4, 11'h000},
    '{8'h43, 8'h03, 4, 11'h032},
    '{8'h25, 8'h60, 5, 11'h001},
    '{8'h25, 8'hC0, 5, 11'h007},
    '{8'h25, 8'h01, 0, 11'h000},
    '{8'h25, 8'h02, 0, 11'h7FF},
    '{8'h3F, 8'hA5, 3, 11'h00A},
    '{8'h40, 8'hE0, 3, 11'h00A},
    '{8'h25, 8'h05, 0, 11'h52F},
    '{8'h25, 8'h00, 0, 11'h523},
    '{8'h3D, 8'hC0, 0, 11'h123},
    '{8'h3D, 8'h80, 0, 11'h523}};
  adc_config_register_bank dut (.CLK(clk), .RST_N(rst_n), .SERIAL_CLK(sclk),
    .SERIAL_SELECT_N(sel_n), .SERIAL_DATA_IN(sdi), .ADC_SAMPLE(smp), .OVERRANGE_IN(ovr),
    .FORMAT_INTERFACE_PIN(fmt), .OVERRANGE_READBACK_PIN(pin), .DATA_OUT(dout),
    .TWOS_COMPLEMENT(twos), .SWING_CODE(swing), .GAIN_HALF_DB(gain),
    .CLOCK_DRIVER_DOUBLE(cdd), .DATA_DRIVER_DOUBLE(ddd), .DC_OFFSET_LOOP_ENABLE(dcl),
    .NOISE_SHAPING_ENABLE(nse), .NOISE_SHAPING_COEF_A(ca), .NOISE_SHAPING_COEF_B(cb),
    .INTERFACE_CLOCK_EDGE(), .FALL_EDGE_LATENCY_STANDBY(), .POWER_DOWN_SWING(),
    .OFFSET_PEDESTAL(ped), .OFFSET_LOOP_TIMING(), .LOW_RATE_MODE(), .SHAPING_PIN_OVERRIDE());
  cfg_ctrl_model ctl (.sclk(sclk), .sel_n(sel_n), .sdi(sdi), .sdo(pin));
  function automatic logic [10:0] obs(input int s);
    case (s)
      0: return dout;
      1: return {9'h000, cdd, ddd};
      2: return {5'h00, dcl, nse, ca};
      3: return {7'h00, cb};
      4: return {5'h00, swing};
      default: return {8'h00, gain};
    endcase
  endfunction
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ctl.xfer(a, d);
    repeat (8) @(negedge clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500000;
    miscompares++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    ovr = 1'b0;
    fmt = 1'b1;
    smp = 11'h123;
    miscompares = 0;
    checked = 0;
    repeat (16) @(negedge clk);
    for (int s = 0; s < 6; s++) chk("reset field", 11'h000, obs(s));
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    $display("done: reset");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk("row field", rows[i].e, obs(rows[i].s));
    end
    $display("done: table");
    wr(8'h3D, 8'h00);
    chk("pin format", 11'h123, dout);
    fmt = 1'b0;
    repeat (4) @(negedge clk);
    chk("twos flag", 11'h001, {10'h000, twos});
    wr(8'h3D, 8'h80);
    $display("done: format pin");
    wr(8'h25, 8'h03);
    d0 = dout;
    @(negedge clk);
    chk("toggle pair", 11'h7FF, d0 ^ dout);
    chk("toggle word", 11'h000, (d0 ^ 11'h2AA) & (d0 ^ 11'h555));
    wr(8'h25, 8'h04);
    d0 = dout;
    repeat (8) @(negedge clk);
    chk("ramp step", d0 + 11'h001, dout);
    $display("done: patterns");
    wr(8'h25, 8'h00);
    ovr = 1'b1;
    repeat (2) @(negedge clk);
    chk("overrange pin", 11'h001, {10'h000, pin});
    wr(8'h00, 8'h01);
    wr(8'h3D, 8'hC0);
    chk("readback data", 11'h080, {3'h0, ctl.rd});
    chk("ignored write", 11'h523, dout);
    wr(8'h00, 8'h01);
    chk("read zero", 11'h000, {3'h0, ctl.rd});
    $display("done: readback");
    wr(8'h00, 8'h03);
    chk("swing cleared", 11'h000, obs(4));
    chk("coef cleared", 11'h000, obs(3));
    repeat (2) @(negedge clk);
    chk("pin role", 11'h001, {10'h000, pin});
    wr(8'h3E, 8'hA0);
    chk("write after reset", 11'h00A, obs(3));
    $display("done: soft reset");
    wr(8'hBF, 8'hA0);
    chk("raw register", 11'h0A0, {3'h0, ped});
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk("hard reset", 11'h000, {3'h0, ped});
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    $display("done: hard reset");
    final_report();
  end
endmodule // adc_config_register_bank_tb_top
